// ### verilog/ewc_defs.svh
`ifndef EWC_DEFS_SVH
`define EWC_DEFS_SVH
// core clock and external memory interface clock periods
`define EWC_CORE_PERIOD_NS 5
`define EWC_EMI_PERIOD_NS  10
// core cycles per interface clock
`define EWC_EMI_CYC   (`EWC_EMI_PERIOD_NS / `EWC_CORE_PERIOD_NS)
// interface clocks that finish an access once acknowledge is high
`define EWC_ACK_TAIL  2
// extra hold clocks for write_hold_cycle set
`define EWC_HOLD_CLKS 1
// field widths
`define EWC_ADDR_W    24
`define EWC_DATA_W    16
`define EWC_WAIT_W    4
`define EWC_CNT_W     6
// mode encodings
`define EWC_MODE_WAIT 2'h1
`define EWC_MODE_ACK  2'h2
`define EWC_MODE_BOTH 2'h3
`define EWC_MODE_WBIT 0
`define EWC_MODE_ABIT 1
`endif

// ### verilog/ewc_pkg.sv
`include "ewc_defs.svh"
package ewc_pkg;
	// ways of lengthening the strobe
	typedef enum logic [1:0] {
		EWC_WAIT_ONLY = `EWC_MODE_WAIT,
		EWC_ACK_ONLY  = `EWC_MODE_ACK,
		EWC_WAIT_ACK  = `EWC_MODE_BOTH
	} ewc_mode_t;
	// sequencer states, one-hot
	typedef enum logic [6:0] {
		EWC_IDLE    = 7'h01,
		EWC_SETUP   = 7'h02,
		EWC_STROBE  = 7'h04,
		EWC_ACKW    = 7'h08,
		EWC_TAIL    = 7'h10,
		EWC_RELEASE = 7'h20,
		EWC_HOLD    = 7'h40
	} ewc_state_t;
	// one write request with its settings
	typedef struct packed {
		logic [`EWC_ADDR_W-1:0] addr;
		logic [`EWC_DATA_W-1:0] data;
		logic [`EWC_WAIT_W-1:0] waits;
		ewc_mode_t              mode;
		logic                   write_hold_cycle;
	} ewc_req_t;
endpackage : ewc_pkg

// ### verilog/ewc_top.sv
`timescale 1ns/100ps
`include "ewc_defs.svh"
// Behaviour
// - lengthen by programmed waits, by acknowledge, or by both.
// - acknowledge is sampled at the interface clock rising edge; low inserts waits.
// - each low acknowledge sample holds the strobe one more interface clock.
// - after acknowledge is seen high, two more interface clocks end the access.
// - strobe lasts one interface clock plus one per programmed wait state.
// - write_hold_cycle set keeps data one extra interface clock after the strobe.
// - select and address lead the strobe by half an interface clock.
// - strobe releases half an interface clock before select and address end.
// - data is driven no later than the strobe falls.
// - data is valid one clock plus wait time before the strobe rises.
module ewc_top (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_req_valid,
	input  wire ewc_pkg::ewc_req_t      i_req,
	input  wire logic                   i_ack,
	output logic                        o_req_ready,
	output logic                        o_done,
	output logic                        o_emi_clk,
	output logic                        o_memory_select_n,
	output logic                        o_wr_n,
	output logic [`EWC_ADDR_W-1:0]      o_addr,
	output logic [`EWC_DATA_W-1:0]      o_data,
	output logic                        o_data_oe
);
	ewc_pkg::ewc_state_t    state_reg;
	ewc_pkg::ewc_state_t    state_next;
	ewc_pkg::ewc_req_t      req_reg;
	logic [`EWC_CNT_W-1:0]  cnt_reg;
	logic [`EWC_CNT_W-1:0]  cnt_next;
	logic [`EWC_CNT_W-1:0]  strobe_len;
	logic [`EWC_CNT_W-1:0]  wr_len_reg;
	logic                   ack_meta_reg;
	logic                   ack_sync_reg;
	logic                   emi_rise;
	logic                   take;
	logic                   use_wait;
	logic                   use_ack;

	// free-running interface clock, a divider of the core clock
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_emi_clk <= 1'h0;
		end else begin
			o_emi_clk <= ~o_emi_clk;
		end
	end

	// the interface clock rises at the coming core edge
	assign emi_rise = ~o_emi_clk;

	// acknowledge comes from another chip, so two flops first;
	// the two-cycle lag can hold the strobe one more interface clock
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_meta_reg <= 1'h1;
			ack_sync_reg <= 1'h1;
		end else begin
			ack_meta_reg <= i_ack;
			ack_sync_reg <= ack_meta_reg;
		end
	end

	assign take     = i_req_valid & state_reg[0];
	// mode bits pick waits, acknowledge or both
	assign use_wait = req_reg.mode[`EWC_MODE_WBIT];
	assign use_ack  = req_reg.mode[`EWC_MODE_ABIT];

	// strobe length in core cycles
	// ack-only mode still gives the base interface clock
	always_comb begin
		if (use_wait) begin
			strobe_len = `EWC_CNT_W'(`EWC_EMI_CYC * (1 + req_reg.waits));
		end else begin
			strobe_len = `EWC_CNT_W'(`EWC_EMI_CYC);
		end
	end

	// sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ewc_pkg::EWC_IDLE: begin
				if (take) begin
					state_next = ewc_pkg::EWC_SETUP;
				end
			end
			ewc_pkg::EWC_SETUP: begin
				state_next = ewc_pkg::EWC_STROBE;
				cnt_next   = strobe_len - `EWC_CNT_W'(1);
			end
			ewc_pkg::EWC_STROBE: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - `EWC_CNT_W'(1);
				end else if (use_ack) begin
					state_next = ewc_pkg::EWC_ACKW;
				end else begin
					state_next = ewc_pkg::EWC_RELEASE;
				end
			end
			ewc_pkg::EWC_ACKW: begin
				// decide only on the interface clock rising edge
				// low sample stays one more interface clock
				if (emi_rise && ack_sync_reg) begin
					state_next = ewc_pkg::EWC_TAIL;
					cnt_next   = `EWC_CNT_W'(`EWC_EMI_CYC * `EWC_ACK_TAIL - 1);
				end
			end
			ewc_pkg::EWC_TAIL: begin
				// two more clocks after acknowledge high
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - `EWC_CNT_W'(1);
				end else begin
					state_next = ewc_pkg::EWC_RELEASE;
				end
			end
			ewc_pkg::EWC_RELEASE: begin
				if (req_reg.write_hold_cycle) begin
					state_next = ewc_pkg::EWC_HOLD;
					cnt_next   = `EWC_CNT_W'(`EWC_EMI_CYC * `EWC_HOLD_CLKS - 1);
				end else begin
					state_next = ewc_pkg::EWC_IDLE;
				end
			end
			ewc_pkg::EWC_HOLD: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - `EWC_CNT_W'(1);
				end else begin
					state_next = ewc_pkg::EWC_IDLE;
				end
			end
			default: begin
				state_next = ewc_pkg::EWC_IDLE;
				cnt_next   = '0;
			end
		endcase
	end

	// state and counter
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ewc_pkg::EWC_IDLE;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// request capture; settings are frozen for the whole access
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			req_reg <= '0;
		end else if (take) begin
			req_reg <= i_req;
		end
	end

	// pins follow the next state so they leave flops aligned with it
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_memory_select_n <= 1'h1;
			o_wr_n            <= 1'h1;
			o_data_oe         <= 1'h0;
			o_req_ready       <= 1'h0;
			o_done            <= 1'h0;
		end else begin
			// select falls in setup, one half clock before the strobe
			// select stays through release, half a clock after the strobe
			o_memory_select_n <= ~(state_next[1] | state_next[2] | state_next[3]
				| state_next[4] | state_next[5]);
			o_wr_n      <= ~(state_next[2] | state_next[3] | state_next[4]);
			o_data_oe   <= ~state_next[0];
			o_req_ready <= state_next[0];
			o_done      <= ~state_reg[0] & state_next[0];
		end
	end

	// data loaded before strobe
	// address and data follow the captured request
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_addr <= '0;
			o_data <= '0;
		end else if (take) begin
			o_addr <= i_req.addr;
			o_data <= i_req.data;
		end
	end

	// strobe low length, seen only by the checks below
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_len_reg <= '0;
		end else begin
			wr_len_reg <= o_wr_n ? '0 : wr_len_reg + `EWC_CNT_W'(1);
		end
	end

	setup_lead_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_wr_n) |-> !$past(o_memory_select_n) && $past(o_memory_select_n, 2))
		else $error("select did not lead strobe by one cycle");

	release_lead_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_wr_n) |-> !o_memory_select_n ##1 o_memory_select_n)
		else $error("select did not trail strobe by one cycle");

	data_drive_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		!o_wr_n |-> o_data_oe && $past(o_data_oe))
		else $error("data not driven with strobe");

	data_valid_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		!o_wr_n |-> $stable(o_data) && $stable(o_addr))
		else $error("data changed under strobe");

	wait_width_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_wr_n) && !use_ack |-> wr_len_reg == strobe_len)
		else $error("strobe width wrong for wait states");

	wait_first_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(state_reg[3]) |-> wr_len_reg == strobe_len && !o_wr_n)
		else $error("acknowledge phase began early");

	ack_stall_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[3] && emi_rise && !ack_sync_reg |=> state_reg[3] [*2])
		else $error("low acknowledge did not stall");

	ack_tail_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[3] && emi_rise && ack_sync_reg |=> !o_wr_n [*4] ##1 o_wr_n)
		else $error("acknowledge tail length wrong");

	hold_on_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_wr_n) && req_reg.write_hold_cycle |-> o_data_oe [*3] ##1 !o_data_oe)
		else $error("extra hold cycle missing");

	hold_off_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_wr_n) && !req_reg.write_hold_cycle |-> o_data_oe ##1 !o_data_oe)
		else $error("data held without hold setting");

	wait_skip_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[2] && cnt_reg == '0 && !use_ack |=> state_reg[5])
		else $error("wait-only access entered acknowledge phase");

	ack_enter_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[2] && cnt_reg == '0 && use_ack |=> state_reg[3])
		else $error("acknowledge phase skipped");

	// decisions only at interface clock rise
	ack_edge_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[3] && !emi_rise |=> state_reg[3])
		else $error("acknowledge phase left between interface clock edges");

	// strobe and select held while stalled
	stall_hold_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[3] |-> !o_wr_n && !o_memory_select_n)
		else $error("strobe or select released while stalled");

	strobe_floor_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_wr_n) |-> wr_len_reg >= strobe_len)
		else $error("strobe shorter than programmed width");

	// strobe follows select by one cycle
	select_lead_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_memory_select_n) |-> o_wr_n ##1 !o_wr_n)
		else $error("strobe did not follow select by one cycle");

	addr_hold_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_memory_select_n) |-> $stable(o_addr))
		else $error("address changed as select ended");

	data_early_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_memory_select_n) |-> o_data_oe)
		else $error("data not enabled ahead of strobe");

	// data still valid at strobe release
	data_release_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_wr_n) |-> $stable(o_data))
		else $error("data changed at strobe release");

	wait_count_a: assert property (
		@(posedge i_core_clk) disable iff (i_rst)
		state_reg[2] && cnt_reg != '0 |=> state_reg[2])
		else $error("wait count cut short");

endmodule : ewc_top

// ### tb/ewc_mem_model.sv
`timescale 1ns/100ps
// far-side memory: keeps the written word, stalls through acknowledge
module ewc_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_emi_clk,
	input  wire logic        i_sel_n,
	input  wire logic        i_wr_n,
	input  wire logic [23:0] i_addr,
	input  wire logic [15:0] i_data,
	input  wire logic        i_oe,
	input  wire logic [31:0] i_stall,
	output logic             o_ack,
	output logic [23:0]      o_addr,
	output logic [15:0]      o_data
);
	int   low_cnt = 0;
	logic emi_d   = 1'b0;
	logic wr_d    = 1'b1;
	// with i_stall 0 answers at once as select falls, else waits i_stall interface clocks; pulled up while deselected
	assign o_ack = i_sel_n | (low_cnt >= i_stall);
	// one low sample per interface clock rising edge
	always @(posedge i_clk) begin
		emi_d <= i_emi_clk;
		wr_d  <= i_wr_n;
		if (i_sel_n)
			low_cnt <= 0;
		else if (i_emi_clk && !emi_d)
			low_cnt <= low_cnt + 1;
		// a released bus reads back inverted, never the last value
		if (i_wr_n && !wr_d) begin
			o_addr <= i_addr;
			o_data <= i_oe ? i_data : ~i_data;
		end
	end
endmodule : ewc_mem_model

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic              clk, rst, valid, ready, done, emi, sel_n, wr_n, oe, ack;
	ewc_pkg::ewc_req_t req;
	logic [23:0]       addr, m_addr;
	logic [15:0]       data, m_data;
	int                stall, failures, num_checks, wl, dl, base;
	// free-running core clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	ewc_top DUT (.i_core_clk(clk), .i_rst(rst), .i_req_valid(valid), .i_req(req),
		.i_ack(ack), .o_req_ready(ready), .o_done(done), .o_emi_clk(emi),
		.o_memory_select_n(sel_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(data),
		.o_data_oe(oe));
	ewc_mem_model MEM (.i_clk(clk), .i_emi_clk(emi), .i_sel_n(sel_n), .i_wr_n(wr_n),
		.i_addr(addr), .i_data(data), .i_oe(oe), .i_stall(stall), .o_ack(ack),
		.o_addr(m_addr), .o_data(m_data));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task close_out;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// one write; wl counts strobe cycles, dl the cycle of done after take
	// start with the interface clock low so acknowledge sampling has a fixed phase
	task xfer(input logic [3:0] w, input ewc_pkg::ewc_mode_t m, input logic h, input int st);
		int n;
		n = 0;
		stall = st;
		while ((ready !== 1'b1 || emi !== 1'b0) && n < 50) begin
			@(negedge clk);
			n++;
		end
		chk("ready for request", 1'b1, ready);
		valid = 1'b1;
		req.addr = {20'hA5C3E, w};
		req.data = ~{12'h3C9, w};
		req.waits = w;
		req.mode = m;
		req.write_hold_cycle = h;
		@(negedge clk);
		valid = 1'b0;
		n = 1;
		wl = 0;
		while (done !== 1'b1 && n < 300) begin
			if (wr_n === 1'b0) begin
				wl++;
				chk("select and data under strobe", 1'b1, oe & ~sel_n);
			end
			@(negedge clk);
			n++;
		end
		dl = n;
		chk("access done", 1'b1, done);
		chk("written address", req.addr, m_addr);
		chk("written data", req.data, m_data);
	endtask : xfer
	task sc_wait;
		for (int w = 0; w < 16; w += 5)
			for (int h = 0; h < 2; h++) begin
				xfer(w[3:0], ewc_pkg::EWC_WAIT_ONLY, h[0], 0);
				chk("strobe length", 2 * (1 + w), wl);
				chk("done cycle", 5 + 2 * w + 2 * h, dl);
			end
	endtask : sc_wait
	// strobe = base clocks, one cycle to the sampling edge, four tail cycles;
	// a stall counts from select falling; only its part past the first sampling edge adds, plus the two-flop acknowledge lag
	task sc_ack;
		xfer(4'h0, ewc_pkg::EWC_ACK_ONLY, 1'b0, 0);
		chk("ack strobe", 7, wl);
		xfer(4'h0, ewc_pkg::EWC_ACK_ONLY, 1'b0, 5);
		chk("ack stall", 15, wl);
	endtask : sc_ack
	task sc_both;
		xfer(4'h2, ewc_pkg::EWC_WAIT_ACK, 1'b1, 0);
		base = wl;
		chk("both strobe", 11, base);
		xfer(4'h2, ewc_pkg::EWC_WAIT_ACK, 1'b0, 1);
		chk("early ack", base, wl);
		xfer(4'h2, ewc_pkg::EWC_WAIT_ACK, 1'b0, 8);
		chk("late ack", 21, wl);
	endtask : sc_both
	// main sequence
	initial begin
		valid = 1'b0;
		req = '0;
		stall = 0;
		failures = 0;
		num_checks = 0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		chk("idle bus", 3'h6, {sel_n, wr_n, oe});
		@(negedge clk);
		rst = 1'b0;
		sc_wait;
		sc_ack;
		sc_both;
		close_out;
	end
	// watchdog: the run needs well under 2000 cycles
	initial begin
		#60000;
		failures++;
		close_out;
	end
endmodule : tb
